//--- design/light_barrier_config_regs.sv
/*
    Parameter register bank: four working copies, four one-time stored copies,
    a status word and the decoded receiver settings.
    Assumes an Avalon-MM master on mclk and a scan pulse from the bus logic.
*/
// The Avalon-MM register port was left to the implementer.
// Notes on behaviour
// - Lock bit 15 of general working word clear: working copies accept writes.
// - Lock bit set: working copies are protected from overwrite.
// - Stored word bit 0 sets itself when that word is programmed.
// - Detect threshold bits 3..1, 24nA to 108nA, default code 000.
// - Reserve threshold bits 6..4, 60nA to 144nA, default code 000.
// - Settle delay bits 15..13 set wake delay, default 000.
// - Result of scan n returns at scan n plus settle plus three.
`timescale 1ns/1ps
module light_barrier_config_regs
    import param_bank_pkg::*;
(
    // Clock and reset.
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    // Avalon-MM slave.
    input  wire logic [param_bank_pkg::ADDR_W-1:0] address,
    input  wire logic                          read,
    input  wire logic                          write,
    input  wire logic [31:0]                   writedata,
    input  wire logic [3:0]                    byteenable,
    output logic      [31:0]                   readdata,
    output logic                               waitrequest,
    // Scan events from the bus front end.
    input  wire logic                          scan_cmd,
    input  wire logic                          scan_start,
    // Decoded settings.
    output logic      [2:0]                    detect_threshold,
    output logic      [2:0]                    reserve_threshold,
    output logic      [2:0]                    settle_delay_select,
    output logic                               working_copy_lock,
    output logic                               result_due
);
    import param_bank_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Storage.

    logic [15:0] working [NUM_WORDS];
    logic [15:0] stored  [NUM_WORDS];
    logic        ack;
    logic [15:0] scan_count;

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [15:0] r;
        r = old;
        if (be[0])
            r[7:0] = wd[7:0];
        if (be[1])
            r[15:8] = wd[15:8];
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Decode.

    wire  [5:0]  idx        = address[7:2];
    wire         is_work    = (idx >= IDX_GENERAL_W) && (idx <= IDX_BUS_W);
    wire         is_stored  = (idx >= IDX_GENERAL_S) && (idx <= IDX_BUS_S);
    wire  [1:0]  word_sel   = idx[1:0];
    wire         lock       = working[0][LOCK_BIT];
    wire         wr_go      = write && !ack;
    wire         work_wr    = wr_go && is_work && !lock;
    // stored words burn once; the flag blocks any second burn.
    wire         stored_wr  = wr_go && is_stored && !stored[word_sel][STORED_FLAG_BIT];
    wire  [3:0]  flags      = {stored[3][0], stored[2][0], stored[1][0], stored[0][0]};
    wire  [31:0] status_wd  = {12'h000, flags, scan_count};
    wire  [31:0] next_rdata = is_work   ? {16'h0000, working[word_sel]} :
                              is_stored ? {16'h0000, stored[word_sel]} :
                              (idx == IDX_STATUS) ? status_wd : UNMAPPED_READ;

    // One wait cycle per access, so every transfer takes exactly two edges.
    assign waitrequest = (read || write) && !ack;

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack      <= 1'b0;
            readdata <= 32'h00000000;
        end
        else
        begin
            ack <= (read || write) && !ack;
            if (read && !ack)
                readdata <= next_rdata;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            working[0] <= GENERAL_RST;
            working[1] <= TRIM_RST;
            working[2] <= RECEIVER_RST;
            working[3] <= BUS_RST;
        end
        else if (work_wr)
            working[word_sel] <= merge(working[word_sel], writedata, byteenable);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            for (int i = 0; i < NUM_WORDS; i++)
                stored[i] <= 16'h0000;
        else if (stored_wr)
        begin
            stored[word_sel] <= merge(stored[word_sel], writedata, byteenable);
            stored[word_sel][STORED_FLAG_BIT] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Settings and scan pipeline.

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            detect_threshold    <= 3'h0;
            reserve_threshold   <= 3'h0;
            settle_delay_select <= 3'h0;
            working_copy_lock   <= 1'b0;
        end
        else
        begin
            detect_threshold    <= working[2][DET_MSB:DET_LSB];
            reserve_threshold   <= working[2][RES_MSB:RES_LSB];
            settle_delay_select <= working[2][SETTLE_MSB:SETTLE_LSB];
            working_copy_lock   <= lock;
        end
    end

    scan_delay u_scan_delay
    (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .scan_cmd   (scan_cmd),
        .scan_start (scan_start),
        .settle_sel (working[2][SETTLE_MSB:SETTLE_LSB]),
        .scan_count (scan_count),
        .result_due (result_due)
    );
endmodule

//--- design/param_bank_pkg.sv
/*
    Constants shared by the parameter register bank: word offsets, field positions,
    reset values and scan pipeline constants.
    Assumes a 32-bit Avalon-MM slave port with word addressing by byte address.
*/
package param_bank_pkg;

    localparam int          DATA_W          = 16;
    localparam int          ADDR_W          = 8;
    localparam int          NUM_WORDS       = 4;

    // Register indices; byte address is four times the index.
    localparam logic [5:0]  IDX_GENERAL_W   = 6'h00;
    localparam logic [5:0]  IDX_TRIM_W      = 6'h01;
    localparam logic [5:0]  IDX_RECEIVER_W  = 6'h02;
    localparam logic [5:0]  IDX_BUS_W       = 6'h03;
    localparam logic [5:0]  IDX_GENERAL_S   = 6'h10;
    localparam logic [5:0]  IDX_TRIM_S      = 6'h11;
    localparam logic [5:0]  IDX_RECEIVER_S  = 6'h12;
    localparam logic [5:0]  IDX_BUS_S       = 6'h13;
    // Status register added for the scan counter and programmed flags.
    localparam logic [5:0]  IDX_STATUS      = 6'h20;

    // Field positions.
    localparam int          LOCK_BIT        = 15;
    localparam int          STORED_FLAG_BIT = 0;
    localparam int          DET_LSB         = 1;
    localparam int          DET_MSB         = 3;
    localparam int          RES_LSB         = 4;
    localparam int          RES_MSB         = 6;
    localparam int          SETTLE_LSB      = 13;
    localparam int          SETTLE_MSB      = 15;

    // Reset values of the working copies.
    localparam logic [15:0] GENERAL_RST     = 16'h0000;
    localparam logic [15:0] TRIM_RST        = 16'h4000;
    localparam logic [15:0] RECEIVER_RST    = 16'h0280;
    localparam logic [15:0] BUS_RST         = 16'h0000;

    // Result returned settling value plus this many scans after the start.
    localparam logic [3:0]  SCAN_EXTRA      = 4'h3;
    localparam logic [31:0] UNMAPPED_READ   = 32'h00000000;

endpackage

//--- design/scan_delay.sv
/*
    Scan command counter: computes at which scan count a started scan's result
    is returned.
    Assumes scan_cmd is a one-cycle pulse from logic on mclk.
*/
`timescale 1ns/1ps
module scan_delay
    import param_bank_pkg::*;
(
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Scan events.
    input  wire logic        scan_cmd,
    input  wire logic        scan_start,
    input  wire logic [2:0]  settle_sel,
    // Results.
    output logic      [15:0] scan_count,
    output logic             result_due
);
    import param_bank_pkg::*;

    logic [15:0] due_count;
    logic        armed;
    wire  [15:0] target = 16'(scan_count + 16'(settle_sel) + 16'(SCAN_EXTRA));
    // The scan whose own number equals the due count returns the result.
    wire         hit    = armed && scan_cmd && (scan_count == due_count);

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scan_count <= 16'h0000;
            due_count  <= 16'h0000;
            armed      <= 1'b0;
            result_due <= 1'b0;
        end
        else
        begin
            result_due <= hit;
            if (scan_cmd)
                scan_count <= 16'(scan_count + 16'h0001);
            if (scan_cmd && scan_start)
            begin
                due_count <= target;
                armed     <= 1'b1;
            end
            else if (hit)
                armed <= 1'b0;
        end
    end
endmodule

//--- bench/param_bank_properties.sv
/* Port checker for the parameter bank.
   Assumes full byte lanes on every write and one mclk domain. */
`timescale 1ns/1ps
module param_bank_properties
    import param_bank_pkg::*;
(
    // Bus side.
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // Scan events and settings.
    input wire logic        scan_cmd,
    input wire logic        scan_start,
    input wire logic [2:0]  detect_threshold,
    input wire logic [2:0]  reserve_threshold,
    input wire logic [2:0]  settle_delay_select,
    input wire logic        working_copy_lock,
    input wire logic        result_due
);
    logic [3:0] burned;
    logic [3:0] left;
    wire        acc_w = write && !waitrequest && byteenable[1:0] == 2'b11;
    wire        hit   = scan_cmd && left == 4'h1;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Shadows: which stored words were burned, and scans still owed.
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n) burned <= 4'h0;
        else if (acc_w && address[7:4] == 4'h4) burned[address[3:2]] <= 1'b1;
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n) left <= 4'h0;
        else if (scan_cmd && scan_start) left <= {1'b0, settle_delay_select} + SCAN_EXTRA;
        else if (scan_cmd && left != 4'h0) left <= left - 4'h1;
    ////////////////////////////////////////////////////////////////////////////////
    AST_WRITE_OPEN:
    assert property (acc_w && address == 8'h08 && !working_copy_lock |-> ##2
        {settle_delay_select, reserve_threshold, detect_threshold} ==
        $past({writedata[15:13], writedata[6:4], writedata[3:1]}, 2))
        else $error("open write not applied");
    AST_WRITE_LOCKED:
    assert property (acc_w && address[7:4] == 4'h0 && working_copy_lock |-> ##2
        {settle_delay_select, reserve_threshold, detect_threshold} ==
        $past({settle_delay_select, reserve_threshold, detect_threshold}, 3) &&
        working_copy_lock)
        else $error("locked write applied");
    AST_STORED_FLAG:
    assert property (read && !waitrequest && address[7:4] == 4'h4 |->
        readdata[0] == burned[address[3:2]]) else $error("stored flag wrong");
    AST_STATUS_FLAGS:
    assert property (read && !waitrequest && address == 8'h80 |->
        readdata[19:16] == burned) else $error("status flags wrong");
    AST_RESET_DEFAULTS:
    assert property ($rose(rst_n) |-> {detect_threshold, reserve_threshold,
        settle_delay_select} == 9'h000) else $error("field defaults wrong");
    AST_SCAN_DUE:
    assert property (hit |=> result_due) else $error("result not due");
    AST_DUE_CAUSE:
    assert property (result_due |-> $past(hit)) else $error("result due early");
endmodule

//--- bench/cfg_host.sv
/* Bus controller model: an Avalon-MM master configuring the bank.
   Assumes the caller lets the task start at the next rising edge. */
`timescale 1ns/1ps
module cfg_host
(
    // Clock.
    input wire logic         mclk,
    // Avalon-MM master.
    output logic [7:0]       address = 8'h00,
    output logic             read = 1'b0,
    output logic             write = 1'b0,
    output logic [31:0]      writedata = 32'h0,
    output logic [3:0]       byteenable = 4'hf,
    input wire logic [31:0]  readdata,
    input wire logic         waitrequest
);
    logic hung = 1'b0;
    // Request held until waitrequest is sampled low at a rising edge.
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        address <= a;
        writedata <= {16'h0000, d};
        write <= w;
        read <= !w;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 100);
        hung = hung | (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        writedata <= ~writedata;
    endtask
endmodule

//--- bench/tb_top.sv
/* Bench for the parameter bank: table of writes, stored words, lock, scans.
   Assumes one 250 MHz clock and the host model as bus master. */
`timescale 1ns/1ps
module tb_top;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        scan_cmd = 1'b0;
    logic        scan_start = 1'b0;
    logic [7:0]  address;
    logic        read, write, waitrequest, working_copy_lock, result_due;
    logic [31:0] writedata, readdata, q;
    logic [3:0]  byteenable;
    logic [2:0]  detect_threshold, reserve_threshold, settle_delay_select;
    int          err_count = 0;
    int          compares = 0;
    // Rows: word address and value; readback and fields should match it.
    logic [7:0]  row_a [5] = '{8'h04, 8'h08, 8'h08, 8'h0c, 8'h00};
    logic [15:0] row_d [5] = '{16'h4000, 16'h2294, 16'h02c8, 16'h0200, 16'h0000};
    always #2 mclk = ~mclk;
    cfg_host host (.mclk, .address, .read, .write, .writedata, .byteenable,
        .readdata, .waitrequest);
    light_barrier_config_regs i_light_barrier_config_regs (.mclk, .rst_n, .address,
        .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .scan_cmd,
        .scan_start, .detect_threshold, .reserve_threshold, .settle_delay_select,
        .working_copy_lock, .result_due);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        host.acc(w, a, d, q);
        if (host.hung)
        begin
            err_count++;
            results;
        end
    endtask
    // One start, then lat plain scans; only the last may return the result.
    task automatic seq(input int lat);
        for (int k = 0; k <= lat; k++)
        begin
            @(posedge mclk);
            scan_cmd <= 1'b1;
            scan_start <= (k == 0);
            @(posedge mclk);
            scan_cmd <= 1'b0;
            @(negedge mclk);
            if (k > 0) chk("result_due", {31'h0, result_due}, {31'h0, k == lat});
        end
    endtask
    initial
    begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        chk("defaults", {22'h0, working_copy_lock, settle_delay_select, reserve_threshold,
            detect_threshold}, 32'h0);
        foreach (row_a[i])
        begin
            bus(1'b1, row_a[i], row_d[i]);
            bus(1'b0, row_a[i], 16'h0000);
            chk("working word", q, {16'h0000, row_d[i]});
            if (row_a[i] == 8'h08) chk("fields", {settle_delay_select, reserve_threshold,
                detect_threshold}, {row_d[i][15:13], row_d[i][6:4], row_d[i][3:1]});
        end
        seq(3);
        bus(1'b1, 8'h08, 16'h2294);
        seq(4);
        bus(1'b1, 8'h40, 16'h0012);
        bus(1'b1, 8'h40, 16'h0034);
        bus(1'b0, 8'h40, 16'h0000);
        chk("stored word", q, 32'h13);
        bus(1'b0, 8'h44, 16'h0000);
        chk("blank stored word", q, 32'h0);
        bus(1'b0, 8'h80, 16'h0000);
        chk("stored flags", {28'h0, q[19:16]}, 32'h1);
        chk("scan count", {16'h0, q[15:0]}, 32'h9);
        bus(1'b1, 8'h24, 16'hffff);
        bus(1'b0, 8'h24, 16'h0000);
        chk("unmapped", q, 32'h0);
        bus(1'b1, 8'h00, 16'h8000);
        bus(1'b1, 8'h08, 16'h0280);
        bus(1'b1, 8'h00, 16'h0000);
        bus(1'b0, 8'h08, 16'h0000);
        chk("locked receiver", q, 32'h2294);
        chk("lock", {31'h0, working_copy_lock}, 32'h1);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        bus(1'b0, 8'h00, 16'h0000);
        chk("lock after reset", {q[31:1], working_copy_lock}, 32'h0);
        results;
    end
endmodule
bind light_barrier_config_regs param_bank_properties i_props (.mclk, .rst_n, .address,
    .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .scan_cmd,
    .scan_start, .detect_threshold, .reserve_threshold, .settle_delay_select,
    .working_copy_lock, .result_due);
